// file: common/irqls_pkg.sv
// Constants for the infrared interrupt-cause and line-status block
package irqls_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_MODE_DEF   = 32'h4180_0004;
  localparam logic [31:0] ADDR_IRQ_DMA    = 32'h4180_0008;
  localparam logic [31:0] ADDR_SRC_MASK   = 32'h4180_000C;
  localparam logic [31:0] ADDR_CAUSE      = 32'h4180_0010;
  localparam logic [31:0] ADDR_LINE_STAT  = 32'h4180_0014;
  localparam logic [31:0] ADDR_LIMIT_LOW  = 32'h4180_001C;
  localparam logic [31:0] ADDR_LIMIT_HIGH = 32'h4180_0020;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CAUSE      = 8'h00;
  localparam logic [7:0] RST_CTRL       = 8'h00;
  localparam logic [7:0] RST_LIMIT_LOW  = 8'h00;
  localparam logic [7:0] RST_LIMIT_HIGH = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CAUSE_LAST_LOAD = 7;
  localparam int CAUSE_RX_ERR    = 6;
  localparam int CAUSE_UNDERRUN  = 5;
  localparam int CAUSE_LAST_DET  = 4;
  localparam int CAUSE_OVERRUN   = 3;
  localparam int CAUSE_LAST_READ = 2;
  localparam int CAUSE_TX_THR    = 1;
  localparam int CAUSE_RX_THR    = 0;
  localparam int LSR_TX_EMPTY    = 7;
  localparam int LSR_LAST_READ   = 5;
  localparam int LSR_FLEN_ERR    = 4;
  localparam int LSR_PHY_ERR     = 3;
  localparam int LSR_CRC_ERR     = 2;
  localparam int LSR_RSVD_ONE    = 1;
  localparam int LSR_RX_EMPTY    = 0;
  localparam int CNF_IRQ_EN      = 0;
  localparam int MODE_LSB        = 0;

  // ----------------------------------------------------------------
  // Modes and counts
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_FIR       = 3'h4;
  localparam logic [2:0] MODE_MIR       = 3'h2;
  localparam logic [3:0] MIR_ABORT_ONES = 4'h7;
  localparam logic [7:0] MODE_DEF_MASK  = 8'h1F;
  localparam logic [7:0] IRQ_DMA_MASK   = 8'h0D;

  typedef enum logic [1:0] {
    IRQLS_RX_IDLE,
    IRQLS_RX_FRAME,
    IRQLS_RX_DROP
  } irqls_rx_t;

endpackage

// file: design/irqls_sticky.sv
// Vector of sticky flags where setting wins over clearing
`timescale 1ns/1ps
module irqls_sticky
  import irqls_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Events
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // Flags
  output logic      [W-1:0] q
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (W < 1)
  begin : g_bad_width
    $error("irqls_sticky: W must be at least 1");
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  wire logic [W-1:0] next_q;

  assign next_q = set | (q & ~clr);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      q <= '0;
    else
      q <= next_q;
  end

endmodule // irqls_sticky

// file: design/irqls_top.sv
// Interrupt-cause and line-status logic of the infrared controller
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module irqls_top
  import irqls_pkg::*;
#(
  parameter int LW = 7
)
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          resetn,
  // APB slave
  input  wire logic [31:0]   paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Receive path events
  input  wire logic          rx_begin_flag,
  input  wire logic          rx_byte,
  input  wire logic          rx_last_loaded,
  input  wire logic          rx_last_detect,
  input  wire logic          rx_crc_bad,
  input  wire logic          fir_bad_symbol,
  input  wire logic          mir_bit_valid,
  input  wire logic          mir_bit,
  input  wire logic          cpu_last_read,
  input  wire logic          rx_overrun,
  input  wire logic          rx_overrun_serviced,
  // Transmit path events
  input  wire logic          tx_underrun,
  input  wire logic          tx_underrun_serviced,
  input  wire logic          tx_fifo_empty,
  input  wire logic          tx_idle,
  // FIFO levels
  input  wire logic [LW-1:0] tx_level,
  input  wire logic [LW-1:0] tx_threshold,
  input  wire logic [LW-1:0] rx_level,
  input  wire logic [LW-1:0] rx_threshold,
  input  wire logic          rx_fifo_empty,
  // Outputs
  output logic               irq,
  output logic               rx_discard,
  output logic      [2:0]    op_mode
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (LW < 1 || LW > 16)
  begin : g_bad_level
    $error("irqls_top: LW must be 1 to 16");
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [7:0] mode_definition;
  logic [7:0] irq_dma_config;
  logic [7:0] interrupt_source_mask;
  logic [7:0] rx_frame_limit_low;
  logic [7:0] rx_frame_limit_high;
  logic [7:0] rd_mask;

  wire logic hit_mode   = (paddr == ADDR_MODE_DEF);
  wire logic hit_cnf    = (paddr == ADDR_IRQ_DMA);
  wire logic hit_mask   = (paddr == ADDR_SRC_MASK);
  wire logic hit_cause  = (paddr == ADDR_CAUSE);
  wire logic hit_lsr    = (paddr == ADDR_LINE_STAT);
  wire logic hit_lo     = (paddr == ADDR_LIMIT_LOW);
  wire logic hit_hi     = (paddr == ADDR_LIMIT_HIGH);
  wire logic hit_any    = hit_mode | hit_cnf | hit_mask | hit_cause | hit_lsr
                          | hit_lo | hit_hi;
  wire logic setup_rd   = psel & ~penable & ~pwrite;
  wire logic done       = psel & penable;
  wire logic wr_done    = done & pwrite;
  wire logic cause_rd   = done & ~pwrite & hit_cause;
  wire logic lsr_rd     = done & ~pwrite & hit_lsr;

  assign pready  = 1'b1;
  assign pslverr = done & ~hit_any;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_definition       <= RST_CTRL;
      irq_dma_config        <= RST_CTRL;
      interrupt_source_mask <= RST_CTRL;
      rx_frame_limit_low    <= RST_LIMIT_LOW;
      rx_frame_limit_high   <= RST_LIMIT_HIGH;
    end
    else if (wr_done)
    begin
      if (hit_mode)
        mode_definition <= pwdata[7:0] & MODE_DEF_MASK;
      if (hit_cnf)
        irq_dma_config <= pwdata[7:0] & IRQ_DMA_MASK;
      if (hit_mask)
        interrupt_source_mask <= pwdata[7:0];
      if (hit_lo)
        rx_frame_limit_low <= pwdata[7:0];
      if (hit_hi)
        rx_frame_limit_high <= pwdata[7:0];
    end
  end

  assign op_mode = mode_definition[MODE_LSB +: 3];
  wire logic mode_fir = (op_mode == MODE_FIR);
  wire logic mode_mir = (op_mode == MODE_MIR);

  // ----------------------------------------------------------------
  // Frame length tracking
  // ----------------------------------------------------------------
  irqls_rx_t   rx_state;
  irqls_rx_t   next_rx_state;
  logic [15:0] byte_cnt;
  logic [15:0] next_byte_cnt;
  logic        flen_hit;
  wire  [15:0] frame_limit = {rx_frame_limit_high, rx_frame_limit_low};

  always_comb
  begin
    next_rx_state = rx_state;
    next_byte_cnt = byte_cnt;
    flen_hit      = 1'b0;
    case (rx_state)
      IRQLS_RX_IDLE:
      begin
        if (rx_begin_flag)
        begin
          next_rx_state = IRQLS_RX_FRAME;
          next_byte_cnt = '0;
        end
      end
      IRQLS_RX_FRAME:
      begin
        if (rx_begin_flag)
          next_byte_cnt = '0;
        else if (rx_byte && byte_cnt >= frame_limit)
        begin
          flen_hit      = 1'b1;
          next_rx_state = IRQLS_RX_DROP;
        end
        else if (rx_last_detect)
          next_rx_state = IRQLS_RX_IDLE;
        else if (rx_byte)
          next_byte_cnt = byte_cnt + 16'h0001;
      end
      IRQLS_RX_DROP:
      begin
        if (rx_begin_flag)
        begin
          next_rx_state = IRQLS_RX_FRAME;
          next_byte_cnt = '0;
        end
      end
      default:
      begin
        next_rx_state = IRQLS_RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_state <= IRQLS_RX_IDLE;
      byte_cnt <= '0;
    end
    else
    begin
      rx_state <= next_rx_state;
      byte_cnt <= next_byte_cnt;
    end
  end

  assign rx_discard = (rx_state == IRQLS_RX_DROP);

  // ----------------------------------------------------------------
  // MIR abort pattern counter
  // ----------------------------------------------------------------
  logic [3:0] ones_cnt;
  logic [3:0] next_ones_cnt;

  always_comb
  begin
    next_ones_cnt = ones_cnt;
    if (!mode_mir || (mir_bit_valid && !mir_bit))
      next_ones_cnt = '0;
    else if (mir_bit_valid && ones_cnt <= MIR_ABORT_ONES)
      next_ones_cnt = ones_cnt + 4'h1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ones_cnt <= '0;
    else
      ones_cnt <= next_ones_cnt;
  end

  wire logic mir_abort = mode_mir & mir_bit_valid & mir_bit
                         & (ones_cnt == MIR_ABORT_ONES);
  wire logic phy_set   = (mode_fir & fir_bad_symbol) | mir_abort;

  // ----------------------------------------------------------------
  // Line status flags
  // ----------------------------------------------------------------
  logic [3:0] lsr_q;
  wire  [3:0] lsr_set = {cpu_last_read, flen_hit, phy_set, rx_crc_bad};
  wire  [3:0] lsr_clr = {4{lsr_rd}} & rd_mask[LSR_CRC_ERR +: 4];

  irqls_sticky #(.W(4)) u_lsr_flags
  (
    .clk    (clk),
    .resetn (resetn),
    .set    (lsr_set),
    .clr    (lsr_clr),
    .q      (lsr_q)
  );

  wire logic tx_empty = tx_fifo_empty & tx_idle;
  wire [7:0] lsr_val  = {tx_empty, 1'b0, lsr_q, 1'b1, rx_fifo_empty};

  // ----------------------------------------------------------------
  // Interrupt cause flags
  // ----------------------------------------------------------------
  logic       loaded_seen;
  logic [4:0] cause_q;
  wire  [7:0] ier = interrupt_source_mask;
  wire logic  last_read_ok = cpu_last_read & ier[CAUSE_LAST_READ] & loaded_seen;
  wire  [4:0] cause_set = {rx_last_loaded,
                           tx_underrun & ier[CAUSE_UNDERRUN],
                           rx_last_detect & ier[CAUSE_LAST_DET],
                           rx_overrun & ier[CAUSE_OVERRUN],
                           last_read_ok};
  wire  [4:0] cause_clr = {cause_rd & rd_mask[CAUSE_LAST_LOAD],
                           tx_underrun_serviced,
                           cause_rd & rd_mask[CAUSE_LAST_DET],
                           rx_overrun_serviced,
                           cause_rd & rd_mask[CAUSE_LAST_READ]};

  irqls_sticky #(.W(5)) u_cause_flags
  (
    .clk    (clk),
    .resetn (resetn),
    .set    (cause_set),
    .clr    (cause_clr),
    .q      (cause_q)
  );

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      loaded_seen <= 1'b0;
    else
      loaded_seen <= rx_last_loaded | (loaded_seen & ~cpu_last_read);
  end

  wire logic err_any  = ier[CAUSE_RX_ERR] & (|lsr_q[2:0]);
  wire logic tx_below = (tx_level < tx_threshold);
  wire logic rx_above = (rx_level >= rx_threshold);
  wire [7:0] cause_val = {cause_q[4], err_any, cause_q[3:1], cause_q[0],
                          tx_below, rx_above};

  assign irq = irq_dma_config[CNF_IRQ_EN] & (|(cause_val & ier));

  // ----------------------------------------------------------------
  // Read data capture
  // ----------------------------------------------------------------
  wire [7:0] rd_val = hit_cause ? cause_val :
                      hit_lsr   ? lsr_val :
                      hit_mode  ? mode_definition :
                      hit_cnf   ? irq_dma_config :
                      hit_mask  ? interrupt_source_mask :
                      hit_lo    ? rx_frame_limit_low :
                      hit_hi    ? rx_frame_limit_high : 8'h00;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rd_mask <= RST_CAUSE;
    else if (setup_rd)
      rd_mask <= rd_val;
  end

  assign prdata = {24'h0000_00, rd_mask};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_len_error;
    (rx_state == IRQLS_RX_FRAME) && rx_byte && !rx_begin_flag
      && (byte_cnt >= frame_limit);
  endsequence

  sequence s_drop_until_flag;
    rx_discard && lsr_q[LSR_FLEN_ERR - LSR_CRC_ERR];
  endsequence

  sequence s_mir_abort;
    (ones_cnt == 4'h0) ##0 (mode_mir && mir_bit_valid && mir_bit)[*8];
  endsequence

  sequence s_detect_clear;
    cause_rd && rd_mask[CAUSE_LAST_DET] && !rx_last_detect;
  endsequence

  chk_last_load_set: assert property (rx_last_loaded |=> cause_q[4])
    else $error("last-loaded flag not set");
  chk_load_before_read: assert property ($rose(cause_q[0]) |-> $past(loaded_seen))
    else $error("last-read flag rose before last-loaded");
  chk_error_cause: assert property ((ier[CAUSE_RX_ERR] && rx_crc_bad) |=> cause_val[6])
    else $error("receive error cause missing");
  chk_underrun_hold: assert property (cause_q[3] && !tx_underrun_serviced |=> cause_q[3])
    else $error("underrun flag dropped early");
  chk_detect_set: assert property (rx_last_detect && ier[CAUSE_LAST_DET] |=> cause_q[2])
    else $error("last-detect flag not set");
  chk_overrun_set: assert property (rx_overrun && ier[CAUSE_OVERRUN] |=> cause_q[1])
    else $error("overrun flag not set");
  chk_length_abort: assert property (s_len_error |=> s_drop_until_flag)
    else $error("length error did not abort frame");
  chk_mir_ones: assert property (s_mir_abort |=> lsr_q[LSR_PHY_ERR - LSR_CRC_ERR])
    else $error("MIR abort pattern not flagged");
  chk_irq_gate: assert property (!irq_dma_config[CNF_IRQ_EN] |-> !irq)
    else $error("interrupt raised while globally disabled");
  chk_read_clear: assert property (s_detect_clear |=> !cause_q[2])
    else $error("read did not clear last-detect flag");
  chk_set_wins: assert property (lsr_rd && rx_crc_bad |=> lsr_q[0])
    else $error("CRC event lost under clearing read");
  chk_phy_set_wins: assert property (lsr_rd && phy_set |=> lsr_q[1])
    else $error("PHY event lost under clearing read");

endmodule // irqls_top

// file: testbench/irqls_frame_src.sv
// Far-side model: receive path that delivers one frame of events
`timescale 1ns/1ps
module irqls_frame_src
  import irqls_pkg::*;
(
  // Clock and command
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [7:0] n_bytes,
  input  wire logic       crc_fail,
  // Receive events
  output logic            rx_begin_flag,
  output logic            rx_byte,
  output logic            rx_last_loaded,
  output logic            rx_last_detect,
  output logic            rx_crc_bad,
  output logic            busy
);
  logic [8:0] step = '0;
  initial {rx_begin_flag, rx_byte, rx_last_loaded, rx_last_detect, rx_crc_bad} = '0;
  assign busy = (step != 9'h0);
  // ----------------------------------------------------------------
  // Begin flag, bytes, last byte loaded, then detect with CRC result
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    {rx_begin_flag, rx_byte, rx_last_loaded, rx_last_detect, rx_crc_bad} <= '0;
    if (start && !busy)
    begin
      rx_begin_flag <= 1'b1;
      step          <= 9'h1;
    end
    else if (busy)
    begin
      if (step <= {1'b0, n_bytes})
        rx_byte <= 1'b1;
      else if (step == {1'b0, n_bytes} + 9'h1)
        rx_last_loaded <= 1'b1;
      else
      begin
        rx_last_detect <= 1'b1;
        rx_crc_bad     <= crc_fail;
      end
      step <= (step == {1'b0, n_bytes} + 9'h2) ? 9'h0 : step + 9'h1;
    end
  end
endmodule // irqls_frame_src

// file: testbench/infrared_irq_line_status_bench.sv
// Self-checking bench for the interrupt-cause and line-status block
`timescale 1ns/1ps
module infrared_irq_line_status_bench
  import irqls_pkg::*;
;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, perr;
  logic [31:0] paddr = '0, pwdata = '0, prdata;
  logic [5:0] ev = '0;
  logic mir_bit_valid = 0, mir_bit = 0, tx_fifo_empty = 1, tx_idle = 1, rx_fifo_empty = 1;
  logic [6:0] tx_level = '0, tx_threshold = '0, rx_level = '0, rx_threshold = 7'h1;
  logic irq, rx_discard, start = 0, crc_fail = 0, busy;
  logic [2:0] op_mode;
  logic [7:0] n_bytes = '0;
  logic rx_begin_flag, rx_byte, rx_last_loaded, rx_last_detect, rx_crc_bad;
  int mismatches = 0, n_tests = 0;
  always #5 clk = ~clk;
  irqls_top irqls_top_i (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_begin_flag(rx_begin_flag),
    .rx_byte(rx_byte), .rx_last_loaded(rx_last_loaded), .rx_last_detect(rx_last_detect),
    .rx_crc_bad(rx_crc_bad), .fir_bad_symbol(ev[5]), .mir_bit_valid(mir_bit_valid),
    .mir_bit(mir_bit), .cpu_last_read(ev[0]), .rx_overrun(ev[1]),
    .rx_overrun_serviced(ev[2]), .tx_underrun(ev[3]), .tx_underrun_serviced(ev[4]),
    .tx_fifo_empty(tx_fifo_empty), .tx_idle(tx_idle), .tx_level(tx_level),
    .tx_threshold(tx_threshold), .rx_level(rx_level), .rx_threshold(rx_threshold),
    .rx_fifo_empty(rx_fifo_empty), .irq(irq), .rx_discard(rx_discard), .op_mode(op_mode));
  irqls_frame_src irqls_frame_src_i (.clk(clk), .start(start), .n_bytes(n_bytes),
    .crc_fail(crc_fail), .rx_begin_flag(rx_begin_flag), .rx_byte(rx_byte),
    .rx_last_loaded(rx_last_loaded), .rx_last_detect(rx_last_detect),
    .rx_crc_bad(rx_crc_bad), .busy(busy));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(a, 1'b1, {24'h0, d}, r);
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] m, input logic [7:0] e,
                    input string nm);
    logic [31:0] r;
    apb(a, 1'b0, 32'h0, r);
    check(nm, {24'h0, e}, r & {24'h0, m});
  endtask
  task automatic pulse(input logic [5:0] m);
    ev <= m;
    @(posedge clk);
    ev <= '0;
    @(posedge clk);
  endtask
  task automatic frame(input logic [7:0] n, input logic f);
    n_bytes  <= n;
    crc_fail <= f;
    start    <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (2) @(posedge clk);
    while (busy)
      @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  task automatic mir(input int ones);
    mir_bit_valid <= 1'b1;
    mir_bit       <= 1'b1;
    repeat (ones) @(posedge clk);
    mir_bit <= 1'b0;
    @(posedge clk);
    mir_bit_valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic results;
    $display("n_tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_levels;
    rd(ADDR_CAUSE, 8'hFF, 8'h00, "cause reset");
    rd(ADDR_LINE_STAT, 8'hFF, 8'h83, "status reset");
    rd(32'h4180_0040, 8'hFF, 8'h00, "unmapped");
    check("pslverr", 32'h1, perr);
    check("pready", 32'h1, pready);
    tx_idle       <= 1'b0;
    rx_fifo_empty <= 1'b0;
    tx_level      <= 7'h2;
    tx_threshold  <= 7'h3;
    rx_level      <= 7'h5;
    rx_threshold  <= 7'h5;
    @(posedge clk);
    rd(ADDR_LINE_STAT, 8'h81, 8'h00, "status busy");
    rd(ADDR_CAUSE, 8'h03, 8'h03, "levels on");
    tx_level      <= 7'h3;
    rx_level      <= 7'h4;
    tx_idle       <= 1'b1;
    rx_fifo_empty <= 1'b1;
    @(posedge clk);
    rd(ADDR_CAUSE, 8'h03, 8'h00, "levels off");
  endtask
  task automatic t_frame;
    wr(ADDR_SRC_MASK, 8'hFF);
    wr(ADDR_IRQ_DMA, 8'h01);
    wr(ADDR_LIMIT_LOW, 8'h10);
    frame(8'h3, 1'b0);
    check("irq frame", 32'h1, irq);
    rd(ADDR_CAUSE, 8'hFF, 8'h90, "cause frame");
    rd(ADDR_CAUSE, 8'hFF, 8'h00, "cause cleared");
    check("irq idle", 32'h0, irq);
    pulse(6'h01);
    rd(ADDR_CAUSE, 8'hFF, 8'h04, "last read");
    rd(ADDR_LINE_STAT, 8'hFF, 8'hA3, "status last read");
    rd(ADDR_LINE_STAT, 8'hFF, 8'h83, "status cleared");
    pulse(6'h01);
    rd(ADDR_CAUSE, 8'h04, 8'h00, "read without load");
  endtask
  task automatic t_errors;
    wr(ADDR_SRC_MASK, 8'h40);
    wr(ADDR_LIMIT_LOW, 8'h02);
    frame(8'h4, 1'b1);
    check("discard", 32'h1, rx_discard);
    rd(ADDR_CAUSE, 8'h40, 8'h40, "cause error");
    rd(ADDR_LINE_STAT, 8'h1C, 8'h14, "length crc");
    rd(ADDR_CAUSE, 8'h40, 8'h00, "error gone");
    frame(8'h2, 1'b0);
    check("discard end", 32'h0, rx_discard);
    rd(ADDR_LINE_STAT, 8'h1C, 8'h00, "limit exact");
    wr(ADDR_MODE_DEF, 8'h04);
    check("mode fir", 32'h4, op_mode);
    pulse(6'h20);
    rd(ADDR_LINE_STAT, 8'h08, 8'h08, "fir symbol");
    pulse(6'h20);
    fork
      rd(ADDR_LINE_STAT, 8'h08, 8'h08, "phy under read");
      begin
        @(posedge clk);
        ev <= 6'h20;
        @(posedge clk);
        ev <= '0;
      end
    join
    rd(ADDR_LINE_STAT, 8'h08, 8'h08, "phy kept");
    wr(ADDR_MODE_DEF, 8'h02);
    check("mode mir", 32'h2, op_mode);
    mir(7);
    rd(ADDR_LINE_STAT, 8'h08, 8'h00, "seven ones");
    mir(8);
    rd(ADDR_LINE_STAT, 8'h08, 8'h08, "eight ones");
  endtask
  task automatic t_run_errors;
    wr(ADDR_SRC_MASK, 8'h00);
    pulse(6'h0A);
    rd(ADDR_CAUSE, 8'h28, 8'h00, "gated");
    wr(ADDR_SRC_MASK, 8'h28);
    pulse(6'h0A);
    rd(ADDR_CAUSE, 8'h28, 8'h28, "runs set");
    rd(ADDR_CAUSE, 8'h28, 8'h28, "runs held");
    check("irq on", 32'h1, irq);
    wr(ADDR_IRQ_DMA, 8'h00);
    check("irq off", 32'h0, irq);
    pulse(6'h14);
    rd(ADDR_CAUSE, 8'h28, 8'h00, "serviced");
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset_levels();
    t_frame();
    t_errors();
    t_run_errors();
    results();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule // infrared_irq_line_status_bench
